// [mdpf_pkg.sv]
/*
  Constants and types of the multidrop slave packet framer:
  framing bytes, codes, field layout, timing.
  Assumes a single 10 MHz core clock.
*/
package mdpf_pkg;

  // ----------------------------------------------------------------
  // Framing characters
  // ----------------------------------------------------------------
  localparam logic [7:0] MDPF_STX       = 8'h02;
  localparam logic [7:0] MDPF_CR        = 8'h0d;
  localparam logic [7:0] MDPF_ESC       = 8'h07;
  localparam logic [7:0] MDPF_ESC_STX   = 8'h30;  // Escape pair for 0x02
  localparam logic [7:0] MDPF_ESC_CR    = 8'h31;  // Escape pair for 0x0d
  localparam logic [7:0] MDPF_ESC_ESC   = 8'h32;  // Escape pair for 0x07
  localparam logic [3:0] MDPF_CK_BASE   = 4'h3;   // High nibble of a sum char

  // ----------------------------------------------------------------
  // Addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] MDPF_ADDR_MIN  = 8'h10;
  localparam logic [7:0] MDPF_ADDR_MAX  = 8'hfe;
  localparam logic [7:0] MDPF_ADDR_EXT  = 8'hff;

  // ----------------------------------------------------------------
  // Command codes (upper nibble of the command/response byte)
  // ----------------------------------------------------------------
  localparam logic [3:0] MDPF_CMD_PROD_ID = 4'h3;
  localparam logic [3:0] MDPF_CMD_VERSION = 4'h4;
  localparam logic [3:0] MDPF_CMD_RESET   = 4'h5;
  localparam logic [3:0] MDPF_CMD_ACK_PF  = 4'h6;  // power_loss_acknowledge_cmd

  // Reply status codes, never zero in a reply
  localparam logic [2:0] MDPF_STS_OK      = 3'h1;
  localparam logic [2:0] MDPF_STS_BAD_CMD = 3'h2;

  // ----------------------------------------------------------------
  // Packet sizing
  // ----------------------------------------------------------------
  localparam logic [7:0] MDPF_MIN_LOGICAL = 8'h04;  // Addr, cmd, two sum chars
  localparam logic [7:0] MDPF_MAX_COUNT   = 8'hff;
  localparam logic [7:0] MDPF_ID_LEN      = 8'h02;  // Product id string length

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MDPF_CLK_HZ     = 10000000;
  localparam int MDPF_BAUD       = 9600;
  localparam int MDPF_BIT_CYCLES = MDPF_CLK_HZ / MDPF_BAUD;

  // Command/response byte layout
  typedef struct packed {
    logic [3:0] cmd;
    logic       unacked_reboot_flag;
    logic [2:0] status;   // reply_status_bit2 .. reply_status_bit0
  } mdpf_cmdrsp_t;

endpackage : mdpf_pkg

// [mdpf_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an async active-high reset.
*/
`timescale 1ns/10ps
module mdpf_fifo import mdpf_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                            (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire              empty = (wr_ptr_reg == rd_ptr_reg);
  wire              push  = in_valid_i && !full;
  wire              pop   = out_ready_i && !empty;

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];

  // Pointers carry one extra wrap bit so full and empty differ
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge core_clk_i) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
  end

endmodule : mdpf_fifo

// [mdpf_uart.sv]
/*
  Character receiver and transmitter, 8N1, LSB first.
  Assumes a line input synchronous to the core clock.
*/
`timescale 1ns/10ps
module mdpf_uart import mdpf_pkg::*; #(
  parameter int BIT_CYCLES = MDPF_BIT_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Line
  input  wire logic       rx_i,
  output logic            tx_o,
  // Received characters
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  // Characters to send
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic            tx_busy_o
);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic        rx_busy_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_sh_reg;
  logic        rx_valid_reg;
  wire         rx_tick = rx_busy_reg && (rx_cnt_reg == 16'h0000);

  assign rx_data_o  = rx_sh_reg;
  assign rx_valid_o = rx_valid_reg;

  // Sample mid-bit: start bit checked, eight data bits, stop bit
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_busy_reg  <= 1'b0;
      rx_cnt_reg   <= 16'h0000;
      rx_bit_reg   <= 4'h0;
      rx_sh_reg    <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rx_i) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= BIT_HALF;
          rx_bit_reg  <= 4'h0;
        end
      end else if (!rx_tick) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= BIT_LAST;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rx_i) begin
          rx_busy_reg <= 1'b0; // Glitch, not a start bit
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg  <= 1'b0;
          rx_valid_reg <= rx_i; // Framing error drops char R01
        end else if (rx_bit_reg != 4'h0) begin
          rx_sh_reg <= {rx_i, rx_sh_reg[7:1]}; // R01
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [9:0]  tx_sh_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0]  tx_left_reg;
  logic        tx_line_reg;
  wire         tx_idle = (tx_left_reg == 4'h0);

  assign tx_ready_o = tx_idle;
  assign tx_busy_o  = !tx_idle;
  assign tx_o       = tx_line_reg;

  // Frame is stop, data, start; shifted out from the low end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sh_reg   <= 10'h3ff;
      tx_cnt_reg  <= 16'h0000;
      tx_left_reg <= 4'h0;
      tx_line_reg <= 1'b1;
    end else if (tx_idle) begin
      tx_line_reg <= 1'b1;
      if (tx_valid_i) begin
        tx_sh_reg   <= {1'b1, tx_data_i, 1'b0}; // R01
        tx_left_reg <= 4'ha;
        tx_cnt_reg  <= 16'h0000;
      end
    end else if (tx_cnt_reg == 16'h0000) begin
      tx_line_reg <= tx_sh_reg[0];
      tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
      tx_cnt_reg  <= BIT_LAST;
    end else begin
      tx_cnt_reg <= tx_cnt_reg - 16'h0001;
      if (tx_cnt_reg == 16'h0001) tx_left_reg <= tx_left_reg - 4'h1;
    end
  end

endmodule : mdpf_uart

// [mdpf_framer.sv]
/*
  Slave packet framer for a multidrop command protocol.
  Delimits and checks packets, answers built-in commands,
  reports every accepted command on the user side.
  Assumes a half-duplex transceiver whose driver follows tx_oe_o.
*/
// How it works
// R01: Characters are 8N1, LSB first.
// R02: STX opens, CR closes every packet.
// R03: Order: STX, addr, cmd, data, two sums, CR.
// R04: Each STX restarts assembly, discarding earlier bytes.
// R05: Accept own address only; echo it back.
// R06: Station addresses lie in 0x10 to 0xFE.
// R07: Address 0xFF marks an extended address.
// R08: Master sends flag and status as zero.
// R09: Reply echoes command bits, nonzero status.
// R10: Reply flag set until power-fail acknowledge.
// R11: Reset command reboots to power-up state.
// R12: Product query answers an ASCII id string.
// R13: Command nibble, flag bit, three status bits.
// R14: Sum mod 256, nibbles plus 0x30, high first.
// R15: Escape 0x07 then 0,1,2; else invalid.
// R16: Bad packets are dropped without reply.
// R17: Drive the line only while replying.
`timescale 1ns/10ps
module mdpf_framer import mdpf_pkg::*; #(
  parameter int          BIT_CYCLES    = MDPF_BIT_CYCLES,
  parameter int          FIFO_DEPTH    = 16,
  parameter logic [15:0] PROD_ID_ASCII = 16'h3432  // Arbitrary id string
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Half-duplex line
  input  wire logic       rx_i,
  output logic            tx_o,
  output logic            tx_oe_o,
  // Configuration
  input  wire logic [7:0] own_addr_i,
  // Accepted command report
  output logic            cmd_valid_o,
  output logic [3:0]      cmd_code_o,
  output logic [7:0]      cmd_len_o,
  // Status
  output logic            unacked_reboot_flag_o,
  output logic            reboot_o,
  output logic            rx_overrun_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic needs_stuff(input logic [7:0] b);
    needs_stuff = (b == MDPF_STX) || (b == MDPF_CR) || (b == MDPF_ESC);
  endfunction : needs_stuff

  function automatic logic [7:0] sum_char(input logic [3:0] nib);
    sum_char = {MDPF_CK_BASE, nib};
  endfunction : sum_char

  typedef enum logic [6:0] {
    ST_HUNT  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_BODY  = 7'b0000100,
    ST_ESC   = 7'b0001000,
    ST_DROP  = 7'b0010000,
    ST_REPLY = 7'b0100000,
    ST_FLUSH = 7'b1000000
  } mdpf_state_t;

  // ----------------------------------------------------------------
  // Internal reset: power-on or reset command
  // ----------------------------------------------------------------
  logic soft_rst_reg;
  wire  blk_rst = rst_i | soft_rst_reg;  // Glitch-free: a flop drives it

  // ----------------------------------------------------------------
  // Character layer and receive buffer
  // ----------------------------------------------------------------
  logic [7:0] rx_byte;
  logic       rx_byte_valid;
  logic       fifo_in_ready;
  logic [7:0] rd_byte;
  logic       rd_valid;
  logic       rd_ready;
  logic [7:0] tx_byte;
  logic       tx_valid;
  logic       tx_ready;
  logic       tx_busy;

  mdpf_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .core_clk_i (core_clk_i),
    .rst_i      (blk_rst),
    .rx_i       (rx_i),
    .tx_o       (tx_o),
    .rx_data_o  (rx_byte),
    .rx_valid_o (rx_byte_valid),
    .tx_data_i  (tx_byte),
    .tx_valid_i (tx_valid),
    .tx_ready_o (tx_ready),
    .tx_busy_o  (tx_busy)
  );

  // Buffer soaks up characters while a reply is being sent
  mdpf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (blk_rst),
    .in_data_i   (rx_byte),
    .in_valid_i  (rx_byte_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (rd_byte),
    .out_valid_o (rd_valid),
    .out_ready_i (rd_ready)
  );

  // ----------------------------------------------------------------
  // Parser state
  // ----------------------------------------------------------------
  mdpf_state_t  state_reg;
  logic [7:0]   addr_reg;
  mdpf_cmdrsp_t cmd_reg;
  logic [7:0]   count_reg;
  logic [7:0]   sum_reg;
  logic [7:0]   prev1_reg;
  logic [7:0]   prev2_reg;
  logic         unacked_reg;
  logic         overrun_reg;
  logic         cmd_valid_reg;
  logic [7:0]   len_reg;
  logic         oe_reg;
  logic [3:0]   code_reg;

  // Parser stalls during a reply so the buffer can really fill
  wire parsing = !(state_reg inside {ST_REPLY, ST_FLUSH});
  assign rd_ready = parsing;
  wire take      = rd_valid && parsing;

  // Byte classification
  wire is_stx    = (rd_byte == MDPF_STX);
  wire is_cr     = (rd_byte == MDPF_CR);
  wire is_esc    = (rd_byte == MDPF_ESC);
  wire esc_ok    = (rd_byte >= MDPF_ESC_STX) && (rd_byte <= MDPF_ESC_ESC); // R15
  wire [7:0] unstuffed = (rd_byte == MDPF_ESC_STX) ? MDPF_STX :
                         (rd_byte == MDPF_ESC_CR)  ? MDPF_CR  : MDPF_ESC;
  wire [7:0] logical   = (state_reg == ST_ESC) ? unstuffed : rd_byte;
  wire push      = take && !is_stx && !is_cr &&
                   ((state_reg == ST_BODY && !is_esc) ||
                    (state_reg == ST_ESC && esc_ok));

  // End-of-packet checks; the last two logical bytes are the sum chars
  wire [7:0] pay_sum  = sum_reg - prev1_reg - prev2_reg; // R14
  wire sum_ok    = (prev2_reg == sum_char(pay_sum[7:4])) &&
                   (prev1_reg == sum_char(pay_sum[3:0])); // R14
  wire addr_ok   = (addr_reg == own_addr_i) && (addr_reg != MDPF_ADDR_EXT) &&  // R07
                   (own_addr_i >= MDPF_ADDR_MIN) && (own_addr_i <= MDPF_ADDR_MAX); // R06
  wire pkt_ok    = (count_reg >= MDPF_MIN_LOGICAL) && sum_ok && addr_ok; // R16
  wire accept    = take && is_cr && (state_reg == ST_BODY) && pkt_ok; // R05

  // ----------------------------------------------------------------
  // Reply assembly
  // ----------------------------------------------------------------
  logic [7:0] idx_reg;
  logic       esc_pend_reg;
  logic       rst_cmd_reg;

  wire [7:0] rep_len   = (cmd_reg.cmd == MDPF_CMD_PROD_ID) ? MDPF_ID_LEN : 8'h00; // R12
  wire       builtin   = (cmd_reg.cmd inside {MDPF_CMD_PROD_ID, MDPF_CMD_RESET,
                                              MDPF_CMD_ACK_PF});
  wire [2:0] rep_sts   = builtin ? MDPF_STS_OK : MDPF_STS_BAD_CMD; // R09
  // Command nibble echoed, flag from reset history, status never zero
  wire [7:0] rep_cmd   = {cmd_reg.cmd, unacked_reg, rep_sts}; // R09 R10 R13
  wire [7:0] rep_sum   = addr_reg + rep_cmd +
                         ((rep_len != 8'h00) ?
                          (PROD_ID_ASCII[15:8] + PROD_ID_ASCII[7:0]) : 8'h00); // R14
  wire [7:0] idx_ck1   = 8'h03 + rep_len;
  wire [7:0] idx_last  = 8'h05 + rep_len;

  // Logical item at the current index: STX, addr, cmd, data, sums, CR
  wire [7:0] item = (idx_reg == 8'h00)       ? MDPF_STX : // R02 R03
                    (idx_reg == 8'h01)       ? addr_reg : // R05
                    (idx_reg == 8'h02)       ? rep_cmd  :
                    (idx_reg == 8'h03 && rep_len != 8'h00) ? PROD_ID_ASCII[15:8] :
                    (idx_reg == 8'h04 && rep_len != 8'h00) ? PROD_ID_ASCII[7:0] :
                    (idx_reg == idx_ck1)     ? sum_char(rep_sum[7:4]) :      // R14
                    (idx_reg == idx_last - 8'h01) ? sum_char(rep_sum[3:0]) :
                    MDPF_CR;
  wire in_payload = (idx_reg != 8'h00) && (idx_reg < idx_ck1);
  wire stuff      = in_payload && needs_stuff(item);
  wire [7:0] esc_sub = (item == MDPF_STX) ? MDPF_ESC_STX :
                       (item == MDPF_CR)  ? MDPF_ESC_CR  : MDPF_ESC_ESC;

  assign tx_valid = (state_reg == ST_REPLY);
  assign tx_byte  = esc_pend_reg ? esc_sub : (stuff ? MDPF_ESC : item);     // R15
  wire   tx_take  = tx_valid && tx_ready;

  // ----------------------------------------------------------------
  // Parser and reply sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge blk_rst) begin
    if (blk_rst) begin
      state_reg    <= ST_HUNT;
      addr_reg     <= 8'h00;
      cmd_reg      <= '0;
      count_reg    <= 8'h00;
      sum_reg      <= 8'h00;
      prev1_reg    <= 8'h00;
      prev2_reg    <= 8'h00;
      idx_reg      <= 8'h00;
      esc_pend_reg <= 1'b0;
      rst_cmd_reg  <= 1'b0;
    end else if (take && is_stx) begin
      state_reg <= ST_ADDR; // R04
      count_reg <= 8'h00;
      sum_reg   <= 8'h00;
    end else if (take && is_cr) begin
      state_reg   <= accept ? ST_REPLY : ST_HUNT; // R16
      idx_reg     <= 8'h00;
      rst_cmd_reg <= (cmd_reg.cmd == MDPF_CMD_RESET);
    end else if (take) begin
      case (state_reg)
        ST_ADDR: begin
          addr_reg  <= rd_byte;
          sum_reg   <= rd_byte;
          count_reg <= 8'h01;
          state_reg <= ST_BODY;
        end
        ST_BODY: begin
          if (is_esc) state_reg <= ST_ESC;
        end
        ST_ESC: begin
          state_reg <= esc_ok ? ST_BODY : ST_DROP; // R15
        end
        default: state_reg <= state_reg;
      endcase
      if (push) begin
        sum_reg   <= sum_reg + logical;
        prev1_reg <= logical;
        prev2_reg <= prev1_reg;
        count_reg <= count_reg + 8'h01;
        if (count_reg == 8'h01) cmd_reg <= logical; // R13
        if (count_reg == MDPF_MAX_COUNT) state_reg <= ST_DROP;
      end
    end else if (tx_take) begin
      esc_pend_reg <= stuff && !esc_pend_reg;
      if (!stuff || esc_pend_reg) begin
        idx_reg <= idx_reg + 8'h01;
        if (idx_reg == idx_last) state_reg <= ST_FLUSH;
      end
    end else if (state_reg == ST_FLUSH && !tx_busy) begin
      state_reg <= ST_HUNT;
    end
  end

  // Reboot after the reply to a reset command has left the line
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= (state_reg == ST_FLUSH) && !tx_busy && rst_cmd_reg; // R11
    end
  end

  // Flag survives until acknowledged; any reboot sets it again
  always_ff @(posedge core_clk_i or posedge blk_rst) begin
    if (blk_rst) begin
      unacked_reg <= 1'b1; // R10
    end else if (accept && cmd_reg.cmd == MDPF_CMD_ACK_PF) begin
      unacked_reg <= 1'b0; // R10
    end
  end

  // ----------------------------------------------------------------
  // User-side reports and line enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge blk_rst) begin
    if (blk_rst) begin
      cmd_valid_reg <= 1'b0;
      len_reg       <= 8'h00;
      code_reg      <= 4'h0;
      overrun_reg   <= 1'b0;
      oe_reg        <= 1'b0;
    end else begin
      // Master flag and status bits are ignored
      cmd_valid_reg <= accept; // R08
      if (accept) len_reg <= count_reg - MDPF_MIN_LOGICAL;
      if (accept) code_reg <= cmd_reg.cmd;
      if (rx_byte_valid && !fifo_in_ready) overrun_reg <= 1'b1;
      // Driver on for the whole reply, off once the last stop bit ends
      oe_reg <= (state_reg == ST_REPLY) || (state_reg == ST_FLUSH && tx_busy); // R17
    end
  end

  assign cmd_valid_o           = cmd_valid_reg;
  assign cmd_code_o            = code_reg;
  assign cmd_len_o             = len_reg;
  assign unacked_reboot_flag_o = unacked_reg;
  assign reboot_o              = soft_rst_reg;
  assign rx_overrun_o          = overrun_reg;
  assign tx_oe_o               = oe_reg;

endmodule : mdpf_framer

// [mdpf_framer_sva.sv]
/* Checker for the framer's ports.
   Assumes a bind to every framer instance. */
`timescale 1ns/10ps
module mdpf_framer_sva import mdpf_pkg::*; #(
  parameter int BIT_CYCLES = 8
) (
  // Clock, reset and line
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       rx_i,
  input wire logic       tx_o,
  input wire logic       tx_oe_o,
  // Configuration, command report and status
  input wire logic [7:0] own_addr_i,
  input wire logic       cmd_valid_o,
  input wire logic [3:0] cmd_code_o,
  input wire logic [7:0] cmd_len_o,
  input wire logic       unacked_reboot_flag_o,
  input wire logic       reboot_o,
  input wire logic       rx_overrun_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  logic [31:0] run_reg;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Burst length: a reply holds at least six whole characters
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) run_reg <= 32'h0;
    else run_reg <= tx_oe_o ? run_reg + 32'h1 : 32'h0;
  end
  property p_idle_high; !tx_oe_o |-> tx_o; endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle low");
  property p_oe_lead; $fell(tx_o) |-> tx_oe_o && $past(tx_oe_o); endproperty
  a_oe_lead: assert property (p_oe_lead) else $error("no driver");
  property p_reply; $rose(cmd_valid_o) |-> ##[0:2] tx_oe_o; endproperty
  a_reply: assert property (p_reply) else $error("no reply");
  property p_oe_cause; $rose(tx_oe_o) |-> cmd_valid_o || $past(cmd_valid_o); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("stray reply");
  property p_frame; $fell(tx_oe_o) |-> run_reg >= 60 * BIT_CYCLES; endproperty
  a_frame: assert property (p_frame) else $error("short reply");
  property p_own; own_addr_i < MDPF_ADDR_MIN || own_addr_i > MDPF_ADDR_MAX |-> !cmd_valid_o; endproperty
  a_own: assert property (p_own) else $error("bad own addr");
  property p_code; $changed(cmd_code_o) |-> cmd_valid_o || reboot_o; endproperty
  a_code: assert property (p_code) else $error("code moved");
  property p_ack; $fell(unacked_reboot_flag_o) |-> ##[0:2] cmd_code_o == MDPF_CMD_ACK_PF; endproperty
  a_ack: assert property (p_ack) else $error("flag lost");
  property p_reboot; reboot_o |=> !reboot_o && unacked_reboot_flag_o && !tx_oe_o; endproperty
  a_reboot: assert property (p_reboot) else $error("bad reboot");
  property p_boot_why; reboot_o |-> $past(cmd_code_o) == MDPF_CMD_RESET; endproperty
  a_boot_why: assert property (p_boot_why) else $error("stray reboot");
  c_accept: cover property ($rose(cmd_valid_o));
  c_reboot: cover property (reboot_o);
  c_ack: cover property ($fell(unacked_reboot_flag_o));
endmodule : mdpf_framer_sva

// [mdpf_host_model.sv]
/* Host master: sends packets, queues replies in rq.
   Assumes a muted receiver while the framer drives. */
`timescale 1ns/10ps
module mdpf_host_model #(
  parameter int BC = 8
) (
  // Clock and line
  input  wire logic core_clk_i,
  input  wire logic tx_i,
  input  wire logic tx_oe_i,
  output logic      rx_o
);
  logic       drv_oe = 1'b0;
  logic       drv_bit = 1'b1;
  logic [7:0] rq[$];
  // Released line and muted receiver read high
  assign rx_o = tx_oe_i | !drv_oe | drv_bit;
  // One character, start bit first, LSB first, ns stop bits
  task automatic send(input logic [7:0] b, input int ns);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    drv_oe = 1'b1;
    for (int i = 0; i < 10; i++) begin
      drv_bit = f[i];
      repeat (i == 9 ? BC * ns : BC) @(posedge core_clk_i);
      #1;
    end
  endtask : send
  // Whole packet; md 1 bad sum, 2 bad escape, 3 stray lead-in, 4 short
  task automatic pkt(input logic [7:0] a, input logic [3:0] c, input int n, input int md);
    logic [7:0] s;
    int         ns;
    ns = (md == 3) ? 2 : 1;
    s = a + {c, 4'h0};
    @(posedge core_clk_i);
    #1;
    if (md == 3) begin
      send(8'h02, ns);
      send(8'h55, ns);
    end
    send(8'h02, ns);
    send(a, ns);
    send({c, 4'h0}, ns);
    for (int i = 0; i < n; i++) begin
      s += (i == 0) ? 8'h02 : (i == 1) ? 8'h0d : 8'h07;
      send(8'h07, ns);
      send((md == 2) ? 8'h33 : 8'(8'h30 + i), ns);
    end
    if (md == 1) s = ~s;
    if (md != 4) begin
      send({4'h3, s[7:4]}, ns);
      send({4'h3, s[3:0]}, ns);
    end
    send(8'h0d, ns);
    drv_oe = 1'b0;
  endtask : pkt
  // Reply collector, mid-bit; bad stop gives unknown
  always begin : rx_proc
    logic [7:0] b;
    @(posedge core_clk_i iff (tx_oe_i && !tx_i));
    repeat (BC / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge core_clk_i);
      b[i] = tx_i;
    end
    repeat (BC) @(posedge core_clk_i);
    rq.push_back(tx_i ? b : 8'hxx);
  end
endmodule : mdpf_host_model

// [testbench.sv]
/* Bench: a table of packets through the host model.
   Assumes all block files compiled first. */
`timescale 1ns/10ps
module testbench import mdpf_pkg::*; ();
  typedef struct {logic [7:0] oa, a; logic [3:0] c; int n, md; logic [7:0] rsp;} mdpf_row_t;
  localparam int          BC = 8;
  localparam logic [15:0] ID = 16'h3432;  // Arbitrary id string
  logic       clk, rst, rxd, txd, oe, cv, flag, rbt, ovr;
  logic [7:0] own, clen, ll, s, b;
  logic [3:0] ccode, lc;
  logic [7:0] q[$];
  int         bad_count = 0, check_count = 0, nv = 0, nrb = 0, cyc = 0, v0;
  // Own address, sent address, code, data count, fault mode, reply byte
  mdpf_row_t rows[13] = '{'{8'h10, 8'h10, 4'h3, 0, 0, 8'h39}, '{8'h20, 8'h21, 4'h3, 0, 0, 8'h00},
    '{8'h20, 8'hff, 4'h3, 0, 0, 8'h00}, '{8'h0f, 8'h0f, 4'h3, 0, 0, 8'h00},
    '{8'h20, 8'h20, 4'h4, 0, 1, 8'h00}, '{8'h20, 8'h20, 4'h7, 3, 2, 8'h00},
    '{8'h20, 8'h20, 4'h7, 3, 0, 8'h7a}, '{8'h20, 8'h20, 4'h4, 0, 3, 8'h4a},
    '{8'h20, 8'h20, 4'h3, 0, 4, 8'h00}, '{8'h20, 8'h20, 4'h6, 0, 0, 8'h61},
    '{8'h20, 8'h20, 4'h3, 0, 0, 8'h31}, '{8'hfe, 8'hfe, 4'h5, 0, 0, 8'h51},
    '{8'hfe, 8'hfe, 4'h3, 0, 0, 8'h39}};
  mdpf_framer #(.BIT_CYCLES(BC), .FIFO_DEPTH(16), .PROD_ID_ASCII(ID)) mdpf_framer_i (
    .core_clk_i(clk), .rst_i(rst), .rx_i(rxd), .tx_o(txd), .tx_oe_o(oe), .own_addr_i(own),
    .cmd_valid_o(cv), .cmd_code_o(ccode), .cmd_len_o(clen), .unacked_reboot_flag_o(flag),
    .reboot_o(rbt), .rx_overrun_o(ovr));
  mdpf_host_model #(.BC(BC)) mdpf_host_model_i (.core_clk_i(clk), .tx_i(txd), .tx_oe_i(oe),
    .rx_o(rxd));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Record reports and reboots; cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cv) begin
      nv++;
      lc = ccode;
      ll = clen;
    end
    if (rbt) nrb++;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    rst = 1'b1;
    own = 8'h10;
    repeat (20) @(posedge clk);
    chk("driver off", 8'h00, {7'h0, oe});
    chk("flag at reset", 8'h01, {7'h0, flag});
    #1 rst = 1'b0;
    foreach (rows[r]) begin
      own = rows[r].oa;
      v0 = nv;
      mdpf_host_model_i.rq.delete();
      mdpf_host_model_i.pkt(rows[r].a, rows[r].c, rows[r].n, rows[r].md);
      repeat (200) @(posedge clk);
      for (int k = 0; k < 3000 && oe; k++) @(posedge clk);
      repeat (2 * BC) @(posedge clk);
      #1;
      q = mdpf_host_model_i.rq;
      chk("accepted", {7'h0, rows[r].rsp != 8'h00}, 8'(nv - v0));
      if (rows[r].rsp == 8'h00) chk("silence", 8'h00, 8'(q.size()));
      else begin
        chk("code", {4'h0, rows[r].c}, {4'h0, lc});
        chk("length", 8'(rows[r].n), ll);
        chk("reply start", MDPF_STX, q[0]);
        chk("reply addr", rows[r].a, q[1]);
        chk("reply cmd", rows[r].rsp, q[2]);
        chk("reply end", MDPF_CR, q[$]);
        if (rows[r].c == MDPF_CMD_PROD_ID) chk("id", ID[15:8], q[3]);
        if (rows[r].c == MDPF_CMD_PROD_ID) chk("id", ID[7:0], q[4]);
        s = 8'h00;
        for (int i = 1; i < q.size() - 3; i++) begin
          b = q[i];
          if (b == MDPF_ESC) begin
            i++;
            b = (q[i] == 8'h30) ? 8'h02 : (q[i] == 8'h31) ? 8'h0d : 8'h07;
          end
          s += b;
        end
        chk("sum high", {4'h3, s[7:4]}, q[$-2]);
        chk("sum low", {4'h3, s[3:0]}, q[$-1]);
      end
    end
    chk("reboots", 8'h01, 8'(nrb));
    chk("overrun", 8'h00, {7'h0, ovr});
    give_verdict();
  end
endmodule : testbench
bind mdpf_framer mdpf_framer_sva #(.BIT_CYCLES(BIT_CYCLES)) mdpf_framer_sva_i (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .rx_i(rx_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
  .own_addr_i(own_addr_i), .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o),
  .cmd_len_o(cmd_len_o), .unacked_reboot_flag_o(unacked_reboot_flag_o),
  .reboot_o(reboot_o), .rx_overrun_o(rx_overrun_o));
